// ### hdl/rrc_cfg.svh
// constants for the rotate-right-through-carry slice
`ifndef RRC_CFG_SVH
`define RRC_CFG_SVH
`define RRC_OPC_HI 4'h1
`define RRC_OPC_MID 3'h4
`define RRC_DEST_BIT 8
`define RRC_WORK_RST 8'h00
`define RRC_CARRY_RST 1'h0
`endif

// ### hdl/rrc_pkg.sv
// types for the rotate-right-through-carry slice
package rrc_pkg;
  typedef struct packed {
    logic [7:0] workAcc;
    logic carry;
    logic fileWe;
    logic [7:0] fileAddr;
    logic [7:0] fileData;
    logic done;
  } rrc_state_t;
endpackage

// ### hdl/rrc_rotate_right.sv
// one-cycle rotate right through carry datapath
//
// Overview of operation
// [RL1] opcode 0001 100d ffff ffff decodes as the rotate; one word, one cycle.
// [RL2] the file operand shifts right one place through carry; only carry changes.
// [RL3] destination bit 0 sends the result to the working accumulator.
// [RL4] destination bit 1 writes the result back into the source file register.
// [RL5] old carry enters result bit 7; operand bit 0 becomes the new carry.
`include "rrc_cfg.svh"
module rrc_rotate_right
  import rrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic opValid,
  input wire logic [15:0] opWord,
  output logic [7:0] fileRdAddr,
  input wire logic [7:0] fileRdData,
  output logic fileWe,
  output logic [7:0] fileWrAddr,
  output logic [7:0] fileWrData,
  output logic [7:0] working_accumulator,
  output logic carryFlag,
  output logic isRotate,
  output logic opDone
);

  //----------------------------------------------------------------
  // decode and rotate
  //----------------------------------------------------------------
  function automatic logic decode_rot(input logic [15:0] w);
    decode_rot = (w[15:12] == `RRC_OPC_HI) && (w[11:9] == `RRC_OPC_MID); // RL1
  endfunction

  function automatic logic [8:0] rot_thru_carry(input logic cin, input logic [7:0] v);
    rot_thru_carry = {v[0], cin, v[7:1]}; // RL5
  endfunction

  rrc_state_t state_r;
  rrc_state_t state_nxt;
  logic rotate_right_via_carry_op;
  logic [7:0] rotVal;
  logic newCarry;
  logic wrPending;
  logic fwdHit;
  logic [7:0] operand;

  assign rotate_right_via_carry_op = opValid && decode_rot(opWord);
  assign isRotate = rotate_right_via_carry_op;
  assign fileRdAddr = opWord[7:0]; // RL1

  //----------------------------------------------------------------
  // write-back forwarding
  //----------------------------------------------------------------
  // a write-back lands one edge after its rotate, so a rotate of the same
  // register in the next cycle takes the pending value, not the stale one
  assign wrPending = state_r.fileWe; // RL4
  assign fwdHit = wrPending && (state_r.fileAddr == opWord[7:0]); // RL4
  assign operand = fwdHit ? state_r.fileData : fileRdData; // RL4
  assign {newCarry, rotVal} = rot_thru_carry(state_r.carry, operand); // RL5

  //----------------------------------------------------------------
  // next state
  //----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.fileWe = 1'b0;
    state_nxt.done = 1'b0;
    if (rotate_right_via_carry_op)
    begin
      state_nxt.done = 1'b1; // RL1
      state_nxt.carry = newCarry; // RL2 RL5
      state_nxt.fileAddr = opWord[7:0];
      state_nxt.fileData = rotVal;
      if (opWord[`RRC_DEST_BIT])
      begin
        state_nxt.fileWe = 1'b1; // RL4
      end
      else
      begin
        state_nxt.workAcc = rotVal; // RL3
      end
    end
  end

  //----------------------------------------------------------------
  // state register
  //----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r.workAcc <= `RRC_WORK_RST;
      state_r.carry <= `RRC_CARRY_RST;
      state_r.fileWe <= 1'b0;
      state_r.fileAddr <= 8'h00;
      state_r.fileData <= 8'h00;
      state_r.done <= 1'b0;
    end
    else if (clkEn)
    begin
      state_r <= state_nxt;
    end
  end

  //----------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------
  assign fileWe = state_r.fileWe && clkEn;
  assign fileWrAddr = state_r.fileAddr;
  assign fileWrData = state_r.fileData;
  assign working_accumulator = state_r.workAcc;
  assign carryFlag = state_r.carry;
  assign opDone = state_r.done;

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  one_cycle_done_a: assert property (clkEn ##0 rotate_right_via_carry_op |=> opDone) // RL1
    else $error("rotate did not complete in one cycle");
  carry_gets_bit0_a: assert property (clkEn && rotate_right_via_carry_op
    |=> carryFlag == $past(operand[0])) // RL2
    else $error("carry not loaded from operand bit 0");
  carry_held_a: assert property (clkEn && !rotate_right_via_carry_op |=> $stable(carryFlag)) // RL2
    else $error("carry changed without rotate");
  work_result_a: assert property (clkEn && rotate_right_via_carry_op && !opWord[8]
    |=> working_accumulator == {$past(carryFlag), $past(operand[7:1])}) // RL3
    else $error("working accumulator result wrong");
  work_no_write_a: assert property (clkEn && rotate_right_via_carry_op && !opWord[8]
    |=> !state_r.fileWe) // RL3
    else $error("file written for accumulator destination");
  file_write_a: assert property (clkEn && rotate_right_via_carry_op && opWord[8]
    |=> state_r.fileWe && fileWrAddr == $past(opWord[7:0])) // RL4
    else $error("file write-back missing or wrong address");
  work_kept_a: assert property (clkEn && rotate_right_via_carry_op && opWord[8]
    |=> $stable(working_accumulator)) // RL4
    else $error("working accumulator changed for file destination");
  bit_map_a: assert property (clkEn && rotate_right_via_carry_op
    |=> fileWrData[7] == $past(carryFlag) && fileWrData[6:0] == $past(operand[7:1])) // RL5
    else $error("rotate bit mapping wrong");
  no_decode_a: assert property (clkEn && !rotate_right_via_carry_op |=> !opDone) // RL1
    else $error("done without rotate");

  // decode and freeze
  decode_match_a: assert property (isRotate == (opValid && opWord[15:12] == 4'h1
    && opWord[11:9] == 3'h4)) // RL1
    else $error("rotate decode wrong");
  rd_addr_a: assert property (fileRdAddr == opWord[7:0]) // RL1
    else $error("read address not taken from opcode");
  freeze_a: assert property (!clkEn |=> $stable(state_r)) // RL1
    else $error("state changed while clock enable low");
  we_masked_a: assert property (!clkEn |-> !fileWe) // RL4
    else $error("file write while clock enable low");

  // idle cycles
  acc_held_a: assert property (clkEn && !rotate_right_via_carry_op
    |=> $stable(working_accumulator)) // RL2
    else $error("working accumulator changed without rotate");
  wr_held_a: assert property (clkEn && !rotate_right_via_carry_op
    |=> $stable(fileWrData) && $stable(fileWrAddr)) // RL2
    else $error("write data changed without rotate");
  no_write_idle_a: assert property (clkEn && !rotate_right_via_carry_op |=> !fileWe) // RL4
    else $error("file write without rotate");

  // accumulator destination
  work_addr_a: assert property (clkEn && rotate_right_via_carry_op && !opWord[8]
    |=> fileWrAddr == $past(opWord[7:0])) // RL3
    else $error("write address not tracking rotate");
  acc_from_file_a: assert property (clkEn && rotate_right_via_carry_op && !opWord[8]
    |=> working_accumulator == fileWrData) // RL3
    else $error("accumulator and write data disagree");
  work_bits_a: assert property (clkEn && rotate_right_via_carry_op && !opWord[8]
    |=> working_accumulator[7] == $past(carryFlag)) // RL5
    else $error("old carry not in accumulator bit 7");
  work_low_bits_a: assert property (clkEn && rotate_right_via_carry_op && !opWord[8]
    |=> working_accumulator[6:0] == $past(operand[7:1])) // RL5
    else $error("accumulator low bits wrong");

  // file destination and forwarding
  file_data_a: assert property (clkEn && rotate_right_via_carry_op && opWord[8]
    |=> fileWrData == {$past(carryFlag), $past(operand[7:1])}) // RL4
    else $error("write-back data wrong");
  done_we_a: assert property (fileWe |-> opDone) // RL4
    else $error("file write without done");
  fwd_carry_a: assert property (clkEn && rotate_right_via_carry_op && fwdHit
    |=> carryFlag == $past(state_r.fileData[0])) // RL4
    else $error("forwarded carry wrong");
  fwd_result_a: assert property (clkEn && rotate_right_via_carry_op && fwdHit
    |=> fileWrData[6:0] == $past(state_r.fileData[7:1])) // RL4
    else $error("forwarded result wrong");
  fwd_miss_a: assert property (clkEn && rotate_right_via_carry_op && !fwdHit
    |=> carryFlag == $past(fileRdData[0])) // RL2
    else $error("carry not from file read data");

  rot_to_work_c: cover property (clkEn && rotate_right_via_carry_op && !opWord[8]);
  rot_to_file_c: cover property (clkEn && rotate_right_via_carry_op && opWord[8]);
  carry_in_c: cover property (clkEn && rotate_right_via_carry_op && carryFlag);
  back_to_back_c: cover property (clkEn && rotate_right_via_carry_op ##1
    clkEn && rotate_right_via_carry_op);
  fwd_hit_c: cover property (clkEn && rotate_right_via_carry_op && fwdHit);

endmodule

// ### tb/rrc_file_model.sv
// register file model facing the slice
module rrc_file_model (
  input wire logic sys_clk,
  input wire logic [7:0] rdAddr,
  output logic [7:0] rdData,
  input wire logic we,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 77 + 25);
  assign rdData = mem[rdAddr];
  always_ff @(posedge sys_clk) if (we) mem[wrAddr] <= wrData;
endmodule

// ### tb/rrc_rotate_right_tb_top.sv
// self-checking bench for the rotate slice
module rrc_rotate_right_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, arst_n = 0, clkEn = 0, opValid = 0, fileWe, carryFlag, isRotate, opDone;
  logic [15:0] opWord = 16'h0000;
  logic [7:0] fileRdAddr, fileRdData, fileWrAddr, fileWrData, working_accumulator;
  int n_mismatch = 0, checks_done = 0, seed = 32'hb4f08837;
  int mem [256], acc = 0, cy = 0, res = 0, eWe = 0, eDone = 0, lastA = 0, tk, wq [$];
  bit rstDone = 0;
  always #10 sys_clk = ~sys_clk;
  rrc_rotate_right rrc_rotate_right_inst (.sys_clk, .arst_n, .clkEn, .opValid, .opWord,
    .fileRdAddr, .fileRdData, .fileWe, .fileWrAddr, .fileWrData, .working_accumulator,
    .carryFlag, .isRotate, .opDone);
  rrc_file_model rrc_file_model_inst (.sys_clk, .rdAddr(fileRdAddr), .rdData(fileRdData),
    .we(fileWe), .wrAddr(fileWrAddr), .wrData(fileWrData));
  task chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (exp !== got)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = (i * 77 + 25) & 255;
    repeat (4) @(negedge sys_clk);
    arst_n = 1;
    for (int i = 0; i < 400; i++)
    begin
      @(negedge sys_clk);
      chk("acc", 16'(acc), {8'h00, working_accumulator});
      chk("carry", 16'(cy), {15'h0000, carryFlag});
      chk("done", 16'(eDone), {15'h0000, opDone});
      chk("we", 16'(eWe), {15'h0000, fileWe});
      if (eWe) chk("wr", 16'(wq.pop_front()), {fileWrAddr, fileWrData});
      if (!rstDone && i >= 200 && !eWe)
      begin
        rstDone = 1;
        arst_n = 0;
        clkEn = 0;
        opValid = 0;
        acc = 0;
        cy = 0;
        eDone = 0;
        @(negedge sys_clk);
        arst_n = 1;
        continue;
      end
      clkEn = eDone || ($random(seed) & 7) != 0;
      opValid = 1'($random(seed));
      opWord = 16'($random(seed));
      if (opWord[0]) opWord[15:9] = 7'h0c;
      if (opWord[1]) opWord[7:0] = 8'(lastA);
      tk = clkEn && opValid && opWord[15:9] == 7'h0c;
      #1 chk("rdaddr", {8'h00, opWord[7:0]}, {8'h00, fileRdAddr});
      chk("decode", 16'(opValid && opWord[15:9] == 7'h0c), {15'h0000, isRotate});
      eDone = tk;
      eWe = tk && opWord[8];
      if (tk)
      begin
        res = {cy[0], mem[opWord[7:0]][7:1]};
        cy = mem[opWord[7:0]] & 1;
        lastA = opWord[7:0];
        if (opWord[8]) mem[opWord[7:0]] = res;
        if (opWord[8]) wq.push_back({opWord[7:0], res[7:0]});
        if (!opWord[8]) acc = res;
      end
    end
    $display("random rotate test done");
    end_of_test();
  end
  initial
  begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
endmodule
